/* File: dv/ssd_decode_properties.sv */
// Purpose: port checks  Assumes: single fetch  Notes: bound by name
`timescale 1ns/1ps
module ssd_chk (input wire logic clk, reset, protected_mode, load_valid, load_ready,
  desc_req, desc_valid, ref_valid, seg_ready, input wire logic [15:0] load_selector, ref_offset,
  input wire logic [23:0] global_table_base_reg, local_table_base_reg, desc_addr, desc_base,
  seg_base, input ssd_pkg::ssd_addr_t phys_out);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire ld = load_valid && load_ready;
  chk_fetch_start: assert property (ld && protected_mode |=> desc_req && !load_ready && !seg_ready)
    else $error("no fetch");
  chk_global_addr: assert property (ld && protected_mode && !load_selector[2] |=> desc_addr ==
    $past(global_table_base_reg) + ($past(load_selector) & 16'hfff8)) else $error("bad global");
  chk_local_addr: assert property (ld && protected_mode && load_selector[2] |=> desc_addr ==
    $past(local_table_base_reg) + ($past(load_selector) & 16'hfff8)) else $error("bad local");
  chk_real_base: assert property (ld && !protected_mode |=> seg_ready &&
    seg_base == {$past(load_selector), 4'h0}) else $error("bad real base");
  chk_seg_fill: assert property (desc_valid && !load_ready |=> seg_ready &&
    seg_base == $past(desc_base)) else $error("bad fill");
  chk_phys_sum: assert property (ref_valid && seg_ready && !ld |=> phys_out.valid &&
    phys_out.addr == $past(seg_base) + $past(ref_offset)) else $error("bad sum");
  chk_ref_refuse: assert property (!(ref_valid && seg_ready) |=> !phys_out.valid)
    else $error("stray ref");
  chk_req_pulse: assert property (desc_req |=> !desc_req) else $error("long req");
endmodule : ssd_chk
bind ssd_segment_selector_decode ssd_chk u_chk (.*);

/* File: dv/ssd_mem_model.sv */
// Purpose: descriptor memory  Assumes: one fetch  Notes: slow adds wait
`timescale 1ns/1ps
module ssd_mem_model (input wire logic clk, desc_req, slow,
  input wire logic [23:0] desc_addr, output logic desc_valid, output logic [23:0] desc_base);
  initial begin
    desc_valid = 0;
    desc_base = 0;
  end
  always @(posedge clk) if (desc_req) begin
    repeat (slow ? 5 : 1) @(posedge clk);
    #1 desc_valid = 1;
    desc_base = desc_addr ^ 24'h5a5a5a;
    @(posedge clk) #1 desc_valid = 0;
    desc_base = ~desc_base;
  end
endmodule : ssd_mem_model

/* File: dv/ssd_segment_selector_decode_bench.sv */
// Purpose: random loads and refs  Assumes: 8 ns clock  Notes: LFSR seed 39
`timescale 1ns/1ps
module ssd_segment_selector_decode_bench;
  logic clk = 0, reset = 1, pm = 0, lv = 0, rv = 0, slow = 0, dv, lr, dq, sr;
  logic [15:0] sel = 0, off = 0, r = 16'h0027;
  logic [23:0] gb = 0, lb = 0, da, db, sb, e;
  ssd_pkg::ssd_addr_t po;
  int fail_count = 0, total_checks = 0;
  initial forever #4 clk = ~clk;
  ssd_segment_selector_decode uut (.clk, .reset, .protected_mode(pm), .global_table_base_reg(gb),
    .local_table_base_reg(lb), .load_valid(lv), .load_selector(sel), .ref_valid(rv),
    .ref_offset(off), .load_ready(lr), .desc_req(dq), .desc_addr(da), .desc_valid(dv),
    .desc_base(db), .phys_out(po), .seg_base(sb), .seg_ready(sr));
  ssd_mem_model mem (.clk, .desc_req(dq), .slow, .desc_addr(da), .desc_valid(dv), .desc_base(db));
  function automatic logic [15:0] nx(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx
  task automatic cmp(string n, logic [24:0] s, logic [24:0] x);
    total_checks++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask : cmp
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    #40000 fail_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 reset = 0;
    rv = 1;
    repeat (40) begin
      r = nx(r); sel = r; r = nx(r); pm = r[0]; slow = r[1];
      r = nx(r); gb = {r, 8'h00}; lb = {8'h00, r}; lv = 1;
      e = !pm ? {4'h0, sel, 4'h0} : ((sel[2] ? lb : gb) + (sel & 16'hfff8)) ^ 24'h5a5a5a;
      @(posedge clk) #1 lv = 0;
      for (int i = 0; i < 20 && sr !== 1'b1; i++) @(posedge clk) #1;
      cmp("seg_base", {1'b0, sb}, {1'b0, e});
      cmp("load_ready", {24'h000000, lr}, 25'h0000001);
      if (pm) cmp("desc_addr", {1'b0, da}, {1'b0, (sel[2] ? lb : gb) + (sel & 16'hfff8)});
      repeat (2) begin
        r = nx(r); off = r;
        @(posedge clk) #1 cmp("phys_out", po, {e + off, 1'b1});
      end
    end
    conclude();
  end
endmodule : ssd_segment_selector_decode_bench

/* File: hdl/ssd_pkg.sv */
// Purpose: Shared types and constants for the segment selector decoder
// Assumes: 16-bit selector, 16-bit offset, 24-bit physical space
// Notes:   Descriptor entries are eight bytes long
package ssd_pkg;

  localparam int SEL_W        = 16;
  localparam int OFS_W        = 16;
  localparam int PHYS_W       = 24;
  localparam int INDEX_W      = 13;
  localparam int RPL_W        = 2;
  localparam int RPL_LSB      = 0;
  localparam int TSEL_BIT     = 2;
  localparam int INDEX_LSB    = 3;
  localparam int DESC_SHIFT   = 3;
  localparam logic [PHYS_W-1:0] BASE_RST = 24'h000000;
  localparam logic [SEL_W-1:0]  SEL_RST  = 16'h0000;
  localparam int REAL_SHIFT   = 4;

  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic               table_select_flag;
    logic [RPL_W-1:0]   requested_privilege_field;
  } ssd_selector_t;

  typedef struct packed {
    logic [PHYS_W-1:0] addr;
    logic              valid;
  } ssd_addr_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_DONE  = 4'b1000
  } ssd_state_t;

endpackage : ssd_pkg

/* File: hdl/ssd_segment_selector_decode.sv */
// Purpose: Turns selector:offset pointers into 24-bit physical addresses
// Assumes: Descriptor memory answers a fetch with desc_valid and the
//          24-bit segment base; one segment register is held here
// Notes:   Real mode bypasses descriptor lookup entirely
// Function
// R1: Protected-mode pointer is 16-bit selector plus 16-bit offset.
// R2: Selector splits into 13-bit index, select flag, 2-bit privilege.
// R3: Privilege bits never affect which segment is chosen.
// R4: Select flag zero resolves through the shared global table.
// R5: Select flag one resolves through the current task's table.
// R6: Index is an entry number, up to 8192 segments per table.
// R7: Segments range from one byte up to 64K bytes.
// R8: Offset is an unsigned 16-bit byte position.
// R9: Later references use the stored selector and offset only.
// R10: Real mode uses selector directly as upper base address bits.
// R11: Table base comes from global or local base register.
// R12: Descriptor address is table base plus index times eight.
// R13: Segment base plus offset gives 24-bit physical address.
// R14: Privilege in bits 1:0, select flag bit 2, index 15:3.
`timescale 1ns/1ps
module ssd_segment_selector_decode (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        protected_mode,
  input  wire logic [ssd_pkg::PHYS_W-1:0]  global_table_base_reg,
  input  wire logic [ssd_pkg::PHYS_W-1:0]  local_table_base_reg,
  input  wire logic                        load_valid,
  input  wire logic [ssd_pkg::SEL_W-1:0]   load_selector,
  input  wire logic                        ref_valid,
  input  wire logic [ssd_pkg::OFS_W-1:0]   ref_offset,
  output logic                             load_ready,
  output logic                             desc_req,
  output logic [ssd_pkg::PHYS_W-1:0]       desc_addr,
  input  wire logic                        desc_valid,
  input  wire logic [ssd_pkg::PHYS_W-1:0]  desc_base,
  output ssd_pkg::ssd_addr_t               phys_out,
  output logic [ssd_pkg::PHYS_W-1:0]       seg_base,
  output logic                             seg_ready
);

  ssd_pkg::ssd_state_t                 state_q;
  ssd_pkg::ssd_selector_t              sel_q;
  ssd_pkg::ssd_selector_t              sel_in;
  logic [ssd_pkg::PHYS_W-1:0]          table_base;
  logic [ssd_pkg::PHYS_W-1:0]          desc_off;
  logic [ssd_pkg::PHYS_W-1:0]          real_base;

  assign sel_in = ssd_pkg::ssd_selector_t'(load_selector); // R2 R14
  // Table choice ignores the privilege field
  assign table_base = sel_in.table_select_flag ? local_table_base_reg // R5 R11
                                               : global_table_base_reg; // R4 R3
  assign desc_off = ssd_pkg::PHYS_W'(sel_in.index) << ssd_pkg::DESC_SHIFT; // R6 R12
  assign real_base = ssd_pkg::PHYS_W'(load_selector) << ssd_pkg::REAL_SHIFT; // R10

  // Selector storage for later references
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q <= ssd_pkg::ssd_selector_t'(ssd_pkg::SEL_RST);
    end else if (load_valid && load_ready) begin
      sel_q <= sel_in; // R9
    end
  end

  // Load sequencing and descriptor fetch
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= ssd_pkg::ST_IDLE;
      load_ready <= 1'b1;
      desc_req   <= 1'b0;
      desc_addr  <= ssd_pkg::BASE_RST;
      seg_base   <= ssd_pkg::BASE_RST;
      seg_ready  <= 1'b0;
    end else begin
      unique case (state_q)
        ssd_pkg::ST_IDLE: begin
          if (load_valid) begin
            seg_ready <= 1'b0;
            if (protected_mode) begin
              desc_addr  <= table_base + desc_off; // R12
              desc_req   <= 1'b1;
              load_ready <= 1'b0;
              state_q    <= ssd_pkg::ST_WAIT;
            end else begin
              seg_base  <= real_base; // R10
              seg_ready <= 1'b1;
            end
          end
        end
        ssd_pkg::ST_WAIT: begin
          desc_req <= 1'b0;
          if (desc_valid) begin
            seg_base   <= desc_base; // R13
            seg_ready  <= 1'b1;
            load_ready <= 1'b1;
            state_q    <= ssd_pkg::ST_IDLE;
          end
        end
        ssd_pkg::ST_FETCH, ssd_pkg::ST_DONE: begin
          state_q <= ssd_pkg::ST_IDLE;
        end
        default: begin
          state_q <= ssd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Address formation, unsigned offset, wraps in 24 bits
  always_ff @(posedge clk) begin
    if (reset) begin
      phys_out <= '0;
    end else begin
      phys_out.valid <= ref_valid && seg_ready && load_ready; // R9 R1
      phys_out.addr  <= seg_base + {8'h00, ref_offset}; // R8 R13 R7
    end
  end

endmodule : ssd_segment_selector_decode
